// File: rims_core.sv
`timescale 1ns/100ps
`default_nettype none
module rims_core
  import rims_pkg::*;
#(
  parameter int unsigned SCAN_CYC = RIMS_SCAN_CYC,
  parameter int unsigned STEP_CYC = RIMS_STEP_CYC_DEF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // switch pin, driven level and driven flag from the pad sensor
  input wire logic switch_input,
  input wire logic switch_driven,
  // motor step interface
  output logic step_pulse,
  output logic step_dir,
  // interrupt
  output logic irq
);
  localparam int unsigned SCW = $clog2(SCAN_CYC + 1);
  localparam int unsigned STW = $clog2(STEP_CYC + 1);

  // sequencer, position and bus state
  rims_state_e state_r;
  logic [RIMS_POS_W-1:0] actual_position_r;
  logic [RIMS_POS_W-1:0] target_position_r;
  logic [RIMS_POS_W-1:0] tgt1_r;
  logic [RIMS_POS_W-1:0] tgt2_r;
  logic [RIMS_POS_W-1:0] pos_snap_r;
  logic switch_state_flag_r;
  logic [2:0] drv_sync_r;
  logic [SCW-1:0] scan_cnt_r;
  logic [STW-1:0] step_cnt_r;
  logic [RIMS_IRQ_W-1:0] irq_stat_r;
  logic [RIMS_IRQ_W-1:0] irq_mask_r;
  // decode and helper nets
  logic [RIMS_POS_W-1:0] diff;
  logic at_target;
  logic step_tick;
  logic scan_tick;
  logic wr_acc;
  logic rd_acc;
  logic cmd_wr;
  logic [2:0] cmd_code;
  logic addr_ok;
  logic done_evt;
  logic init_evt;

  // bus decode; every access completes in its first access cycle
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign cmd_wr = wr_acc && (paddr == RIMS_OFS_CMD);
  assign cmd_code = pwdata[2:0];
  assign addr_ok = (paddr == RIMS_OFS_CMD) || (paddr == RIMS_OFS_TGT1) ||
                   (paddr == RIMS_OFS_TGT2) || (paddr == RIMS_OFS_STAT1) ||
                   (paddr == RIMS_OFS_STAT2) || (paddr == RIMS_OFS_IRQ_STAT) ||
                   (paddr == RIMS_OFS_IRQ_MASK);

  // wrapping difference; sign bit picks the shorter way round
  assign diff = target_position_r - actual_position_r;
  assign at_target = (diff == '0);
  assign step_tick = (step_cnt_r == STW'(STEP_CYC - 1));
  assign scan_tick = (scan_cnt_r == SCW'(SCAN_CYC - 1));
  // motion ends only on position match, never on a stall
  assign done_evt = (state_r == RIMS_MOVE) && at_target;
  assign init_evt = (state_r == RIMS_INIT2) && at_target;

  // step rate divider, free running while moving
  // held at zero while idle so a motion commanded from idle starts a full period after its command
  always_ff @(posedge ref_clk) begin
    if (sys_rst || state_r == RIMS_IDLE) begin
      step_cnt_r <= '0;
    end else if (step_tick) begin
      step_cnt_r <= '0;
    end else begin
      step_cnt_r <= step_cnt_r + STW'(1);
    end
  end

  // sequencer; switch flag is deliberately not an input here
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= RIMS_IDLE;
    end else if (cmd_wr && (cmd_code == RIMS_CMD_STOP || cmd_code == RIMS_CMD_CLEAR)) begin
      state_r <= RIMS_IDLE;
    end else if (cmd_wr && cmd_code == RIMS_CMD_INIT) begin
      state_r <= RIMS_INIT1;
    end else if (cmd_wr && cmd_code == RIMS_CMD_GOTO) begin
      state_r <= RIMS_MOVE;
    end else begin
      // otherwise a motion advances only when its target is met
      case (state_r)
        RIMS_INIT1: begin
          if (at_target) begin
            state_r <= RIMS_INIT2;
          end
        end
        RIMS_INIT2, RIMS_MOVE: begin
          if (at_target) begin
            state_r <= RIMS_IDLE;
          end
        end
        default: begin
          state_r <= RIMS_IDLE;
        end
      endcase
    end
  end

  // target register: loaded by commands and by the init sequence
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      target_position_r <= '0;
    end else if (cmd_wr && cmd_code == RIMS_CMD_CLEAR) begin
      target_position_r <= '0;
    end else if (cmd_wr && cmd_code == RIMS_CMD_STOP) begin
      target_position_r <= actual_position_r;
    end else if (cmd_wr && (cmd_code == RIMS_CMD_GOTO || cmd_code == RIMS_CMD_INIT)) begin
      target_position_r <= tgt1_r;
    end else if (state_r == RIMS_INIT1 && at_target) begin
      target_position_r <= tgt2_r;
    end else if (init_evt) begin
      target_position_r <= '0;
    end
  end

  // actual position counter and step outputs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      actual_position_r <= '0;
      step_pulse <= 1'b0;
      step_dir <= 1'b0;
    end else if (cmd_wr && cmd_code == RIMS_CMD_CLEAR) begin
      actual_position_r <= '0;
      step_pulse <= 1'b0;
    end else if (init_evt) begin
      actual_position_r <= '0;
      step_pulse <= 1'b0;
    end else if (state_r != RIMS_IDLE && !at_target && step_tick && !cmd_wr) begin
      step_pulse <= 1'b1;
      step_dir <= diff[RIMS_POS_W-1];
      if (diff[RIMS_POS_W-1]) begin
        actual_position_r <= actual_position_r - RIMS_POS_W'(1);
      end else begin
        actual_position_r <= actual_position_r + RIMS_POS_W'(1);
      end
    end else begin
      step_pulse <= 1'b0;
    end
  end

  // scan period timer
  // runs free of any motion, so status sees a steady refresh rate
  always_ff @(posedge ref_clk) begin
    if (sys_rst || scan_tick) begin
      scan_cnt_r <= '0;
    end else begin
      scan_cnt_r <= scan_cnt_r + SCW'(1);
    end
  end

  // the pad level itself is not needed: the flag tells only whether the pin is driven
  // pad flag from another domain passes three flops
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      drv_sync_r <= '0;
    end else begin
      drv_sync_r <= {drv_sync_r[1:0], switch_driven};
    end
  end

  // flag and position snapshot refresh together on the scan tick
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      switch_state_flag_r <= 1'b0;
      pos_snap_r <= '0;
    end else if (scan_tick) begin
      pos_snap_r <= actual_position_r;
      if (drv_sync_r[2] == drv_sync_r[1]) begin
        switch_state_flag_r <= drv_sync_r[2];
      end
    end
  end

  // target staging registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tgt1_r <= '0;
      tgt2_r <= '0;
    end else if (wr_acc && paddr == RIMS_OFS_TGT1) begin
      tgt1_r <= pwdata[RIMS_POS_W-1:0];
    end else if (wr_acc && paddr == RIMS_OFS_TGT2) begin
      tgt2_r <= pwdata[RIMS_POS_W-1:0];
    end
  end

  // sticky events; a set in the read cycle survives the clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq <= 1'b0;
    end else begin
      if (rd_acc && paddr == RIMS_OFS_IRQ_STAT) begin
        irq_stat_r <= {init_evt, done_evt};
      end else begin
        irq_stat_r <= irq_stat_r | {init_evt, done_evt};
      end
      if (wr_acc && paddr == RIMS_OFS_IRQ_MASK) begin
        irq_mask_r <= pwdata[RIMS_IRQ_W-1:0];
      end
      // one cycle behind the status word so the pin comes straight from a flop
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // apb answer, registered; the read pulls data one cycle early via setup
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= '0;
      // read data is taken from the setup-cycle address, ready for the access cycle
      if (psel && !penable && !pwrite) begin
        case (paddr)
          RIMS_OFS_TGT1: prdata <= {16'h0000, tgt1_r};
          RIMS_OFS_TGT2: prdata <= {16'h0000, tgt2_r};
          RIMS_OFS_STAT1: prdata <= {29'h0, state_r[1], state_r != RIMS_IDLE,
                                     switch_state_flag_r};
          RIMS_OFS_STAT2: prdata <= {16'h0000, pos_snap_r};
          RIMS_OFS_IRQ_STAT: prdata <= {30'h0, irq_stat_r | {init_evt, done_evt}};
          RIMS_OFS_IRQ_MASK: prdata <= {30'h0, irq_mask_r};
          default: prdata <= '0;
        endcase
      end
    end
  end

  // command effects on the sequencer and the position counters
  AST_STOP_HALTS: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cmd_wr && cmd_code == RIMS_CMD_STOP |=> state_r == RIMS_IDLE ##1 !step_pulse)
    else $error("stop did not halt motion");
  AST_CLEAR_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cmd_wr && cmd_code == RIMS_CMD_CLEAR |=> actual_position_r == '0 && target_position_r == '0)
    else $error("position clear failed");
  AST_INIT_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
    init_evt && !cmd_wr |=> actual_position_r == '0 && state_r == RIMS_IDLE)
    else $error("init end did not zero position");
  AST_INIT_ORDER: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_r == RIMS_INIT1 && at_target && !cmd_wr |=> state_r == RIMS_INIT2 &&
    target_position_r == $past(tgt2_r))
    else $error("second motion started wrongly");
  AST_INIT_START: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cmd_wr && cmd_code == RIMS_CMD_INIT |=> state_r == RIMS_INIT1 &&
    target_position_r == $past(tgt1_r))
    else $error("init did not start first motion");
  AST_NO_STALL: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_r == RIMS_MOVE && !at_target && !cmd_wr |=> state_r == RIMS_MOVE)
    else $error("motion ended off target");
  // every step goes the short way and moves the count by one
  AST_SHORT_WAY: assert property (@(posedge ref_clk) disable iff (sys_rst)
    step_pulse |-> step_dir == ($past(diff[RIMS_POS_W-1])))
    else $error("long way taken");
  // snapshot and flag refresh only on the scan tick
  AST_SCAN_SYNC: assert property (@(posedge ref_clk) disable iff (sys_rst)
    scan_tick |=> pos_snap_r == $past(actual_position_r))
    else $error("snapshot not refreshed");
  AST_FLAG_STABLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !scan_tick |=> $stable(switch_state_flag_r))
    else $error("flag changed off period");
  AST_STEP_MOVES: assert property (@(posedge ref_clk) disable iff (sys_rst)
    step_pulse |-> (actual_position_r - $past(actual_position_r)) inside {16'h0001, 16'hFFFF})
    else $error("bad step increment");

  // the bus answers every access at once; only holes in the map raise an error
  AST_APB_READY: assert property (@(posedge ref_clk) disable iff (sys_rst)
    psel && penable |-> pready)
    else $error("access cycle without ready");
  AST_APB_ERROR: assert property (@(posedge ref_clk) disable iff (sys_rst)
    psel && penable |-> pslverr == !addr_ok)
    else $error("error response does not match the map");
  AST_HOLE_READ: assert property (@(posedge ref_clk) disable iff (sys_rst)
    psel && penable && !pwrite && !addr_ok |-> prdata == '0)
    else $error("read of a hole returned data");

  // idle means no step at all; a reached target ends the motion cleanly
  AST_IDLE_QUIET: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_r == RIMS_IDLE |=> !step_pulse)
    else $error("step while idle");
  AST_MOVE_DONE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    done_evt && !cmd_wr |=> state_r == RIMS_IDLE && !step_pulse)
    else $error("motion went on past its target");
  // state only moves on a command or a reached target, so the pad cannot steer it
  AST_STATE_CAUSE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !cmd_wr && !at_target |=> $stable(state_r))
    else $error("state moved without command or target");

  // the flag takes the settled driven flag on the tick and the snapshot holds between ticks
  AST_FLAG_VALUE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    scan_tick && (drv_sync_r[2] == drv_sync_r[1]) |=>
    switch_state_flag_r == $past(drv_sync_r[2]))
    else $error("flag does not follow the pad");
  AST_SNAP_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !scan_tick |=> $stable(pos_snap_r))
    else $error("snapshot changed off period");

  // an event always lands in its sticky bit; a read with no event empties the word
  AST_DONE_LANDS: assert property (@(posedge ref_clk) disable iff (sys_rst)
    done_evt |=> irq_stat_r[RIMS_IRQ_DONE])
    else $error("motion done event lost");
  AST_INIT_LANDS: assert property (@(posedge ref_clk) disable iff (sys_rst)
    init_evt |=> irq_stat_r[RIMS_IRQ_INIT])
    else $error("init done event lost");
  AST_READ_CLEARS: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_acc && (paddr == RIMS_OFS_IRQ_STAT) && !init_evt && !done_evt |=>
    irq_stat_r == '0)
    else $error("status read did not clear");
  AST_IRQ_LEVEL: assert property (@(posedge ref_clk) disable iff (sys_rst)
    |(irq_stat_r & irq_mask_r) |=> irq)
    else $error("interrupt not raised");

  // main scenarios: init end, stop in flight, flag rise, interrupt, wrap past zero
  COV_INIT: cover property (@(posedge ref_clk) disable iff (sys_rst) init_evt);
  COV_STOP: cover property (@(posedge ref_clk) disable iff (sys_rst)
    state_r == RIMS_MOVE && cmd_wr && cmd_code == RIMS_CMD_STOP);
  COV_FLAG: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(switch_state_flag_r));
  COV_IRQ: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(irq));
  COV_WRAP: cover property (@(posedge ref_clk) disable iff (sys_rst)
    step_pulse && step_dir && actual_position_r == 16'hFFFF);
endmodule : rims_core
`default_nettype wire

// File: rims_pkg.sv
// Operation
// - reference init runs two motions, first target then second target
// - when second motion completes, actual position counter clears to zero
// - no stall detection; stepping continues until actual equals target
// - switch flag is one when input driven high or low, zero when floating
// - switch flag refreshes with actual position snapshot every 1024 us
// - switch input and flag never influence state machines, motions or commands
// - switch flag is readable only through the first full-status read
// - immediate stop halts the motion in progress at once
// - position clear zeroes actual position and target position
// - positions are 16-bit two's complement, lsb 1/16 microstep, wrapping
// - direction chosen is the shorter way around the wrapping range
package rims_pkg;
  localparam int unsigned RIMS_POS_W = 16;
  // register byte offsets
  localparam logic [7:0] RIMS_OFS_CMD = 8'h00;
  localparam logic [7:0] RIMS_OFS_TGT1 = 8'h04;
  localparam logic [7:0] RIMS_OFS_TGT2 = 8'h08;
  localparam logic [7:0] RIMS_OFS_STAT1 = 8'h0C;
  localparam logic [7:0] RIMS_OFS_STAT2 = 8'h10;
  localparam logic [7:0] RIMS_OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] RIMS_OFS_IRQ_MASK = 8'h18;
  // command codes written to the command register
  localparam logic [2:0] RIMS_CMD_GOTO = 3'h1;
  localparam logic [2:0] RIMS_CMD_INIT = 3'h2;
  localparam logic [2:0] RIMS_CMD_STOP = 3'h3;
  localparam logic [2:0] RIMS_CMD_CLEAR = 3'h4;
  // status-one fields
  localparam int unsigned RIMS_ST1_SWITCH = 0;
  localparam int unsigned RIMS_ST1_BUSY = 1;
  localparam int unsigned RIMS_ST1_INIT = 2;
  // irq bits: motion done, init done
  localparam int unsigned RIMS_IRQ_W = 2;
  localparam int unsigned RIMS_IRQ_DONE = 0;
  localparam int unsigned RIMS_IRQ_INIT = 1;
  // timing
  localparam int unsigned RIMS_CLK_MHZ = 125;
  localparam int unsigned RIMS_SCAN_US = 1024;
  localparam int unsigned RIMS_SCAN_CYC = RIMS_SCAN_US * RIMS_CLK_MHZ;
  localparam int unsigned RIMS_STEP_CYC_DEF = 64;
  typedef enum logic [1:0] {
    RIMS_IDLE = 2'b00,
    RIMS_MOVE = 2'b01,
    RIMS_INIT1 = 2'b10,
    RIMS_INIT2 = 2'b11
  } rims_state_e;
endpackage : rims_pkg

// File: rims_motor_model.sv
`timescale 1ns/100ps
`default_nettype none
// shaft side of the step interface: counts every pulse outside a mark cycle, so a blocked shaft still counts
module rims_motor_model (
  // clock
  input wire logic ref_clk,
  // step interface from the device
  input wire logic step_pulse,
  input wire logic step_dir,
  // bench control and observation
  input wire logic mark,
  output logic [15:0] pos,
  output logic [15:0] lowest,
  output int steps
);
  // plain 16-bit arithmetic gives the wrapping circle for free
  initial begin
    pos = 16'h0000;
    lowest = 16'h0000;
    steps = 0;
  end
  // mark restarts the step count and the lowest point seen
  always @(posedge ref_clk) begin
    if (mark) begin
      lowest <= pos;
      steps <= 0;
    end else if (step_pulse) begin
      pos <= step_dir ? pos - 16'h0001 : pos + 16'h0001;
      steps <= steps + 1;
      if (step_dir && $signed(pos - 16'h0001) < $signed(lowest)) begin
        lowest <= pos - 16'h0001;
      end
    end
  end
endmodule : rims_motor_model
`default_nettype wire

// File: test_reference_init_motion_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module test_reference_init_motion_sequencer;
  import rims_pkg::*;
  // short scan and step periods keep the run brief
  localparam int SCAN = 20;
  localparam int STEP = 4;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mark = 1'b0;
  logic switch_input = 1'b0, switch_driven = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, irq, step_pulse, step_dir, err;
  logic [15:0] pos, lowest, p, zref = 16'h0000;
  int steps, mismatches = 0, num_checks = 0;

  // 125 MHz clock
  always #4 ref_clk = ~ref_clk;
  // a floating pin shows a changing level, flipped on every rising clock edge
  always @(posedge ref_clk) if (!switch_driven) switch_input <= ~switch_input;

  rims_core #(.SCAN_CYC(SCAN), .STEP_CYC(STEP)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .switch_input(switch_input),
    .switch_driven(switch_driven), .step_pulse(step_pulse), .step_dir(step_dir), .irq(irq));
  rims_motor_model shaft (.ref_clk(ref_clk), .step_pulse(step_pulse), .step_dir(step_dir),
    .mark(mark), .pos(pos), .lowest(lowest), .steps(steps));

  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1);
    chk("access cycles", 32'd1, n);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rd_chk
  task automatic pos_chk(input logic [15:0] e);
    apb(1'b0, RIMS_OFS_STAT2, 32'h0);
    chk("actual", {16'h0, e}, {16'h0, q[15:0]});
  endtask : pos_chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  // the snapshot lags by up to a scan plus the pin synchroniser
  task automatic settle;
    cyc(3 * SCAN + 4);
  endtask : settle
  // only status reads while a motion runs
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, RIMS_OFS_STAT1, 32'h0);
      n++;
    end while (q[RIMS_ST1_BUSY] !== 1'b0 && n < 500);
    chk("busy", 32'h0, {31'h0, q[RIMS_ST1_BUSY]});
  endtask : wait_idle
  // restart the shaft statistics, then issue a command
  task automatic go(input logic [2:0] c);
    mark <= 1'b1;
    @(posedge ref_clk);
    mark <= 1'b0;
    apb(1'b1, RIMS_OFS_CMD, {29'h0, c});
  endtask : go
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  // watchdog: the sequence needs a few thousand cycles at most
  initial begin
    #200000;
    mismatches++;
    results();
  end

  initial begin
    cyc(5);
    sys_rst <= 1'b0;
    cyc(1);
    // reset state, unmapped word, mask readback
    rd_chk("stat1", RIMS_OFS_STAT1, 32'h0);
    pos_chk(16'h0000);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, q);
    apb(1'b1, RIMS_OFS_IRQ_MASK, 32'h3);
    rd_chk("mask", RIMS_OFS_IRQ_MASK, 32'h3);
    // short move while the switch pin becomes driven
    apb(1'b1, RIMS_OFS_TGT1, 32'h5);
    go(RIMS_CMD_GOTO);
    switch_driven <= 1'b1;
    wait_idle();
    chk("steps", 32'd5, steps);
    chk("shaft", 32'h5, {16'h0, pos});
    settle();
    pos_chk(16'h0005);
    apb(1'b0, RIMS_OFS_STAT1, 32'h0);
    chk("switch", 32'h1, {31'h0, q[RIMS_ST1_SWITCH]});
    chk("irq", 32'h1, {31'h0, irq});
    rd_chk("irq stat", RIMS_OFS_IRQ_STAT, 32'h1);
    cyc(2);
    chk("irq", 32'h0, {31'h0, irq});
    rd_chk("irq stat", RIMS_OFS_IRQ_STAT, 32'h0);
    // -2 lies seven steps back, not 65529 forward
    switch_driven <= 1'b0;
    apb(1'b1, RIMS_OFS_TGT1, 32'h0000_FFFE);
    go(RIMS_CMD_GOTO);
    wait_idle();
    chk("steps", 32'd7, steps);
    chk("shaft", 32'hFFFE, {16'h0, pos});
    rd_chk("irq stat", RIMS_OFS_IRQ_STAT, 32'h1);
    settle();
    apb(1'b0, RIMS_OFS_STAT1, 32'h0);
    chk("switch", 32'h0, {31'h0, q[RIMS_ST1_SWITCH]});
    // reference search with its interrupt masked
    apb(1'b1, RIMS_OFS_IRQ_MASK, 32'h0);
    apb(1'b1, RIMS_OFS_TGT1, 32'h0000_FFF0);
    apb(1'b1, RIMS_OFS_TGT2, 32'h0000_FFF6);
    go(RIMS_CMD_INIT);
    apb(1'b0, RIMS_OFS_STAT1, 32'h0);
    chk("init active", 32'h1, {31'h0, q[RIMS_ST1_INIT]});
    wait_idle();
    chk("lowest", 32'hFFF0, {16'h0, lowest});
    chk("shaft", 32'hFFF6, {16'h0, pos});
    chk("steps", 32'd20, steps);
    zref = pos;
    settle();
    pos_chk(16'h0000);
    chk("irq", 32'h0, {31'h0, irq});
    rd_chk("irq stat", RIMS_OFS_IRQ_STAT, 32'h2);
    // long move cut short; the shaft must stay put afterwards
    apb(1'b1, RIMS_OFS_IRQ_MASK, 32'h3);
    apb(1'b1, RIMS_OFS_TGT1, 32'h0000_03E8);
    go(RIMS_CMD_GOTO);
    cyc(10 * STEP);
    apb(1'b1, RIMS_OFS_CMD, {29'h0, RIMS_CMD_STOP});
    cyc(2);
    p = pos;
    settle();
    chk("shaft", {16'h0, p}, {16'h0, pos});
    pos_chk(p - zref);
    // clear zeroes target too, so no motion may follow
    go(RIMS_CMD_CLEAR);
    settle();
    pos_chk(16'h0000);
    chk("steps", 32'd0, steps);
    results();
  end
endmodule : test_reference_init_motion_sequencer
`default_nettype wire
